// ### rtl/mcubfe_pkg.sv
package mcubfe_pkg;

    // ------------------------------------------------------------
    // Bus style selections
    // ------------------------------------------------------------
    localparam logic [1:0] MCUBFE_RSTYLE_RD_N = 2'h0;
    localparam logic [1:0] MCUBFE_RSTYLE_E = 2'h1;
    localparam logic [1:0] MCUBFE_RSTYLE_DS_N = 2'h2;
    localparam logic [1:0] MCUBFE_RSTYLE_FETCH = 2'h3;

    // ------------------------------------------------------------
    // Port pin functions
    // ------------------------------------------------------------
    localparam logic [2:0] MCUBFE_PF_MCU_IO = 3'h0;
    localparam logic [2:0] MCUBFE_PF_MCELL = 3'h1;
    localparam logic [2:0] MCUBFE_PF_PLD_IN = 3'h2;
    localparam logic [2:0] MCUBFE_PF_LATCH_ADDR = 3'h3;
    localparam logic [2:0] MCUBFE_PF_ADDR_IN = 3'h4;
    localparam logic [2:0] MCUBFE_PF_DATA_IN = 3'h5;
    localparam logic [2:0] MCUBFE_PF_PERIPH = 3'h6;
    localparam logic [2:0] MCUBFE_PF_JTAG = 3'h7;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] MCUBFE_PORT_RST = 8'h00;
    localparam logic [15:0] MCUBFE_ADDR_RST = 16'h0000;
    localparam int MCUBFE_PUSH_PULL_PINS = 4;
    localparam int MCUBFE_JTAG_PINS = 2;
    localparam int MCUBFE_SYNC_STAGES = 2;
    // Idle levels of write, read, fetch, strobe and chip select pins
    localparam logic [4:0] MCUBFE_CTRL_IDLE = 5'h1d;

    typedef enum logic [1:0] {
        MCUBFE_ST_IDLE = 2'b00,
        MCUBFE_ST_ADDR = 2'b01,
        MCUBFE_ST_DATA = 2'b11
    } mcubfe_state_t;

    // Bus controls as seen by the logic arrays
    typedef struct packed {
        logic write_n;
        logic read_n;
        logic fetch_n;
        logic latch;
        logic select_n;
    } mcubfe_ctrl_t;

    // Static configuration of one general port
    typedef struct packed {
        logic [7:0][2:0] func;
        logic [7:0] open_drain;
        logic [7:0] fast_slew;
    } mcubfe_port_cfg_t;

    // Drive of one general port
    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe;
        logic [7:0] fast_slew;
    } mcubfe_port_drv_t;

endpackage

// ### rtl/mcubfe_port.sv
`timescale 1ns/100ps
module mcubfe_port
    import mcubfe_pkg::*;
#(
    parameter int OD_LOW = 0,
    parameter int JTAG_OK = 0
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire mcubfe_port_cfg_t cfg_i,
    input wire logic [7:0] mcu_out_i,
    input wire logic [7:0] mcu_dir_i,
    input wire logic [7:0] mcell_i,
    input wire logic [7:0] addr_i,
    output mcubfe_port_drv_t drv_o
);

    // ------------------------------------------------------------
    // Per-pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            drv_o <= '0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                logic val;
                logic en;
                logic od;
                val = 1'b0;
                en = 1'b0;
                case (cfg_i.func[i])
                    MCUBFE_PF_MCU_IO: begin
                        val = mcu_out_i[i];
                        en = mcu_dir_i[i];
                    end
                    MCUBFE_PF_MCELL: begin
                        val = mcell_i[i];
                        en = 1'b1;
                    end
                    MCUBFE_PF_LATCH_ADDR: begin
                        val = addr_i[i];
                        en = 1'b1;
                    end
                    default: begin
                        val = 1'b0;
                        en = 1'b0;
                    end
                endcase
                // JTAG pins stay inputs
                if (JTAG_OK == 0 && cfg_i.func[i] == MCUBFE_PF_JTAG) begin
                    en = 1'b0;
                end
                // Low pins of A and B are push-pull only
                od = cfg_i.open_drain[i] &&
                    (OD_LOW != 0 || i >= MCUBFE_PUSH_PULL_PINS);
                drv_o.dout[i] <= od ? 1'b0 : val;
                drv_o.oe[i] <= od ? (en && !val) : en;
                // Slew option only on push-pull-only pins
                drv_o.fast_slew[i] <= cfg_i.fast_slew[i] &&
                    OD_LOW == 0 && i < MCUBFE_PUSH_PULL_PINS;
            end
        end
    end

endmodule

// ### rtl/mcubfe_front_end.sv
`timescale 1ns/100ps
module mcubfe_front_end
    import mcubfe_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic muxed_bus_i,
    input wire logic write_is_dir_i,
    input wire logic [1:0] read_style_i,
    input wire logic fetch_used_i,
    input wire logic [7:0] lower_addr_data_port_i,
    output logic [7:0] lower_addr_data_port_o,
    output logic [7:0] lower_addr_data_port_oe_o,
    input wire logic [7:0] upper_addr_data_port_i,
    input wire logic bus_ctrl_in_write_i,
    input wire logic bus_ctrl_in_read_i,
    input wire logic bus_ctrl_in_fetch_i,
    input wire logic addr_strobe_alt_i,
    input wire logic chip_select_n_i,
    input wire logic block_select_i,
    input wire logic [7:0] read_data_i,
    input wire logic [7:0] port_a_i,
    input wire logic [7:0] port_b_i,
    input wire logic [7:0] port_c_i,
    input wire mcubfe_port_cfg_t port_a_cfg_i,
    input wire mcubfe_port_cfg_t port_b_cfg_i,
    input wire mcubfe_port_cfg_t port_c_cfg_i,
    input wire logic [23:0] mcu_port_out_i,
    input wire logic [23:0] mcu_port_dir_i,
    input wire logic [7:0] macrocell_group_ab_i,
    input wire logic [7:0] macrocell_group_bc_i,
    output logic [15:0] latched_addr_o,
    output mcubfe_ctrl_t ctrl_o,
    output logic [23:0] pld_port_in_o,
    output logic [7:0] write_data_o,
    output logic write_pulse_o,
    output logic mem_enable_o,
    output logic [1:0] jtag_pins_o,
    output logic [2:0] bus_state_o,
    output mcubfe_port_drv_t port_a_o,
    output mcubfe_port_drv_t port_b_o,
    output mcubfe_port_drv_t port_c_o
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 8 + 8 + 5 + 24;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [7:0] lo_s;
    logic [7:0] hi_s;
    logic wr_s;
    logic rd_s;
    logic ft_s;
    logic as_s;
    logic cs_n_s;
    logic [23:0] ports_s;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Idle pin levels, so release shows no false strobe
            sync1_q <= {16'h0000, MCUBFE_CTRL_IDLE, 24'h00_0000};
            sync2_q <= {16'h0000, MCUBFE_CTRL_IDLE, 24'h00_0000};
        end else begin
            sync1_q <= {lower_addr_data_port_i, upper_addr_data_port_i,
                bus_ctrl_in_write_i, bus_ctrl_in_read_i,
                bus_ctrl_in_fetch_i, addr_strobe_alt_i, chip_select_n_i,
                port_c_i, port_b_i, port_a_i};
            sync2_q <= sync1_q;
        end
    end

    assign {lo_s, hi_s, wr_s, rd_s, ft_s, as_s, cs_n_s, ports_s} = sync2_q;

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    // Read is active-low for all styles except the E clock
    function automatic logic read_active(input logic [1:0] style,
                                         input logic pin);
        read_active = (style == MCUBFE_RSTYLE_E) ? pin : !pin;
    endfunction

    logic rd_act;
    logic wr_act;
    logic sel;
    logic [7:0] port_a_data;

    assign rd_act = write_is_dir_i ?
        (read_active(read_style_i, rd_s) && wr_s) :
        read_active(read_style_i, rd_s);
    assign wr_act = write_is_dir_i ?
        (read_active(read_style_i, rd_s) && !wr_s) : !wr_s;
    assign sel = block_select_i && !cs_n_s;
    // Non-multiplexed hosts may route data through port A
    assign port_a_data = ports_s[7:0];

    // ------------------------------------------------------------
    // Address latch and bus cycle
    // ------------------------------------------------------------
    mcubfe_state_t state_q;
    logic wr_prev_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= MCUBFE_ST_IDLE;
        end else begin
            case (state_q)
                MCUBFE_ST_IDLE: begin
                    if (as_s) begin
                        state_q <= MCUBFE_ST_ADDR;
                    end
                end
                MCUBFE_ST_ADDR: begin
                    if (!as_s) begin
                        state_q <= MCUBFE_ST_DATA;
                    end
                end
                MCUBFE_ST_DATA: begin
                    if (as_s) begin
                        state_q <= MCUBFE_ST_ADDR;
                    end
                end
                default: begin
                    state_q <= MCUBFE_ST_IDLE;
                end
            endcase
        end
    end

    // Transparent while strobe high, held after it falls
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            latched_addr_o <= MCUBFE_ADDR_RST;
        end else if (as_s) begin
            latched_addr_o <= {hi_s, lo_s};
        end
    end

    // ------------------------------------------------------------
    // Data path toward the host
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lower_addr_data_port_o <= MCUBFE_PORT_RST;
            lower_addr_data_port_oe_o <= MCUBFE_PORT_RST;
        end else begin
            lower_addr_data_port_o <= read_data_i;
            // Never drive during the address phase of a muxed bus
            lower_addr_data_port_oe_o <= {8{rd_act && sel && !as_s}};
        end
    end

    // Write data taken on the end of the write strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_prev_q <= 1'b0;
            write_data_o <= MCUBFE_PORT_RST;
            write_pulse_o <= 1'b0;
        end else begin
            wr_prev_q <= wr_act && sel;
            write_pulse_o <= wr_prev_q && !(wr_act && sel);
            if (wr_act && sel) begin
                write_data_o <= muxed_bus_i ? lo_s : port_a_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Logic-array feeds
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_o <= '1;
            pld_port_in_o <= '0;
            mem_enable_o <= 1'b0;
            jtag_pins_o <= '0;
            bus_state_o <= '0;
        end else begin
            ctrl_o.write_n <= !wr_act;
            ctrl_o.read_n <= !rd_act;
            // Generic input when no fetch enable is used
            ctrl_o.fetch_n <= fetch_used_i ? ft_s : ft_s;
            ctrl_o.latch <= as_s;
            ctrl_o.select_n <= cs_n_s;
            pld_port_in_o <= ports_s;
            mem_enable_o <= !cs_n_s;
            jtag_pins_o <= ports_s[16 +: MCUBFE_JTAG_PINS];
            bus_state_o <= {1'b0, state_q} |
                {fetch_used_i && !ft_s, 2'b00};
        end
    end

    // ------------------------------------------------------------
    // General ports
    // ------------------------------------------------------------
    mcubfe_port #(.OD_LOW(0), .JTAG_OK(0)) u_port_a (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .cfg_i(port_a_cfg_i),
        .mcu_out_i(mcu_port_out_i[7:0]),
        .mcu_dir_i(mcu_port_dir_i[7:0]),
        .mcell_i(macrocell_group_ab_i),
        .addr_i(latched_addr_o[7:0]),
        .drv_o(port_a_o)
    );

    mcubfe_port #(.OD_LOW(0), .JTAG_OK(0)) u_port_b (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .cfg_i(port_b_cfg_i),
        .mcu_out_i(mcu_port_out_i[15:8]),
        .mcu_dir_i(mcu_port_dir_i[15:8]),
        .mcell_i(macrocell_group_bc_i),
        .addr_i(latched_addr_o[15:8]),
        .drv_o(port_b_o)
    );

    mcubfe_port #(.OD_LOW(1), .JTAG_OK(0)) u_port_c (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .cfg_i(port_c_cfg_i),
        .mcu_out_i(mcu_port_out_i[23:16]),
        .mcu_dir_i(mcu_port_dir_i[23:16]),
        .mcell_i(macrocell_group_bc_i),
        .addr_i(latched_addr_o[7:0]),
        .drv_o(port_c_o)
    );

endmodule

// ### bench/mcubfe_front_end_properties.sv
`timescale 1ns/100ps
module mcubfe_front_end_properties
    import mcubfe_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic write_is_dir_i,
    input wire logic [1:0] read_style_i,
    input wire logic [7:0] lower_addr_data_port_i,
    input wire logic [7:0] lower_addr_data_port_oe_o,
    input wire logic [7:0] upper_addr_data_port_i,
    input wire logic bus_ctrl_in_write_i,
    input wire logic bus_ctrl_in_read_i,
    input wire logic bus_ctrl_in_fetch_i,
    input wire logic addr_strobe_alt_i,
    input wire logic chip_select_n_i,
    input wire logic block_select_i,
    input wire logic [7:0] port_a_i,
    input wire logic [7:0] port_b_i,
    input wire logic [7:0] port_c_i,
    input wire logic [15:0] latched_addr_o,
    input wire mcubfe_ctrl_t ctrl_o,
    input wire logic [23:0] pld_port_in_o,
    input wire logic write_pulse_o,
    input wire logic mem_enable_o
);
    // ------------------------------------------------------------
    // Inputs pass two sync flops, so four quiet cycles are required
    // ------------------------------------------------------------
    default clocking cb_clk @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_strobe_held;
        addr_strobe_alt_i ##1 (addr_strobe_alt_i &&
            $stable({upper_addr_data_port_i, lower_addr_data_port_i})) [*3];
    endsequence
    sequence s_read_idle;
        (bus_ctrl_in_read_i && read_style_i == MCUBFE_RSTYLE_RD_N) [*4];
    endsequence
    a_addr_capture: assert property (s_strobe_held |->
        latched_addr_o == {upper_addr_data_port_i, lower_addr_data_port_i})
        else $error("latched address does not follow pins");
    a_addr_holds: assert property ((!addr_strobe_alt_i) [*5] |->
        $stable(latched_addr_o)) else $error("latched address moved");
    a_oe_needs_read: assert property (s_read_idle |->
        lower_addr_data_port_oe_o == 8'h00) else $error("drive without read");
    a_select_gates_oe: assert property ((!block_select_i) [*4] |->
        lower_addr_data_port_oe_o == 8'h00) else $error("drive unselected");
    a_oe_on_read: assert property (
        (!bus_ctrl_in_read_i && read_style_i == MCUBFE_RSTYLE_RD_N &&
        !write_is_dir_i && block_select_i && !chip_select_n_i &&
        !addr_strobe_alt_i) [*4] |->
        lower_addr_data_port_oe_o == 8'hff) else $error("no drive on read");
    a_cs_blocks_access: assert property (chip_select_n_i [*5] |->
        !mem_enable_o && !write_pulse_o && lower_addr_data_port_oe_o == 8'h00)
        else $error("access while chip select high");
    a_fetch_to_pld: assert property ($stable(bus_ctrl_in_fetch_i) [*4] |->
        ctrl_o.fetch_n == bus_ctrl_in_fetch_i) else $error("fetch not passed");
    a_write_to_pld: assert property (
        (!write_is_dir_i && $stable(bus_ctrl_in_write_i)) [*4] |->
        ctrl_o.write_n == bus_ctrl_in_write_i) else $error("write not passed");
    a_port_to_pld: assert property (
        $stable({port_c_i, port_b_i, port_a_i}) [*4] |->
        pld_port_in_o == {port_c_i, port_b_i, port_a_i})
        else $error("port pins not passed");
    a_pulse_single: assert property ($rose(write_pulse_o) |=>
        !write_pulse_o) else $error("write pulse too long");
endmodule

bind mcubfe_front_end mcubfe_front_end_properties i_props (
    .clk_i, .reset_n_i, .write_is_dir_i, .read_style_i,
    .lower_addr_data_port_i, .lower_addr_data_port_oe_o,
    .upper_addr_data_port_i, .bus_ctrl_in_write_i, .bus_ctrl_in_read_i,
    .bus_ctrl_in_fetch_i, .addr_strobe_alt_i, .chip_select_n_i,
    .block_select_i, .port_a_i, .port_b_i, .port_c_i, .latched_addr_o,
    .ctrl_o, .pld_port_in_o, .write_pulse_o, .mem_enable_o
);

// ### bench/mcubfe_host_model.sv
`timescale 1ns/100ps
module mcubfe_host_model (
    input wire logic clk_i,
    input wire logic [7:0] lo_pin_i,
    output logic ale_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic [7:0] lo_o,
    output logic [7:0] up_o
);
    initial begin
        ale_o = 1'b0;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        lo_o = 8'h00;
        up_o = 8'h00;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Address held past strobe end so the sync lag cannot catch data
    task automatic addr_ph(input logic [15:0] a);
        up_o = a[15:8];
        lo_o = a[7:0];
        ale_o = 1'b1;
        step(4);
        ale_o = 1'b0;
        step(4);
    endtask
    task automatic wr(input logic [7:0] d);
        lo_o = d;
        wr_n_o = 1'b0;
        step(4);
        wr_n_o = 1'b1;
        step(4);
        lo_o = ~d;
    endtask
    // Released lines show the inverse, never a stale value
    task automatic rd(output logic [7:0] d);
        lo_o = ~lo_o;
        rd_n_o = 1'b0;
        step(6);
        d = lo_pin_i;
        rd_n_o = 1'b1;
        step(5);
    endtask
endmodule

// ### bench/mcubfe_front_end_test.sv
`timescale 1ns/100ps
module mcubfe_front_end_test import mcubfe_pkg::*;;
    logic clk, reset_n, mux, cs_n, bsel, fetch, ale, wr_n, rd_n, wp, men;
    logic wdir, fuse;
    logic [1:0] rsty, jt;
    logic [2:0] bst;
    logic [7:0] mab, mbc;
    logic [7:0] rdat, pa, pb, pc, lo_pin, lo_d, lo_oe, lo_h, up_h, rv, wdat;
    logic [15:0] addr;
    logic [23:0] pout, pdir, ppin;
    mcubfe_port_cfg_t ca, cb, cc;
    mcubfe_ctrl_t ctrl;
    mcubfe_port_drv_t poa, pob, poc;
    int miscompares, checks_done, oe_cnt, wp_cnt, n, m;
    assign lo_pin = (lo_oe & lo_d) | (~lo_oe & lo_h);
    mcubfe_host_model i_mcubfe_host_model (.clk_i(clk), .lo_pin_i(lo_pin),
        .ale_o(ale), .wr_n_o(wr_n), .rd_n_o(rd_n), .lo_o(lo_h), .up_o(up_h));
    mcubfe_front_end i_mcubfe_front_end (
        .clk_i(clk), .reset_n_i(reset_n), .muxed_bus_i(mux),
        .write_is_dir_i(wdir), .read_style_i(rsty), .fetch_used_i(fuse),
        .lower_addr_data_port_i(lo_pin), .lower_addr_data_port_o(lo_d),
        .lower_addr_data_port_oe_o(lo_oe), .upper_addr_data_port_i(up_h),
        .bus_ctrl_in_write_i(wr_n), .bus_ctrl_in_read_i(rd_n),
        .bus_ctrl_in_fetch_i(fetch), .addr_strobe_alt_i(ale),
        .chip_select_n_i(cs_n), .block_select_i(bsel), .read_data_i(rdat),
        .port_a_i(pa), .port_b_i(pb), .port_c_i(pc), .port_a_cfg_i(ca),
        .port_b_cfg_i(cb), .port_c_cfg_i(cc), .mcu_port_out_i(pout),
        .mcu_port_dir_i(pdir), .macrocell_group_ab_i(mab),
        .macrocell_group_bc_i(mbc), .latched_addr_o(addr), .ctrl_o(ctrl),
        .pld_port_in_o(ppin), .write_data_o(wdat), .write_pulse_o(wp),
        .mem_enable_o(men), .jtag_pins_o(jt), .bus_state_o(bst),
        .port_a_o(poa), .port_b_o(pob), .port_c_o(poc));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (|lo_oe) oe_cnt++;
        if (wp === 1'b1) wp_cnt++;
    end
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic t_mux_write();
        i_mcubfe_host_model.addr_ph(16'h3ca5);
        chk(addr, 16'h3ca5);
        chk(bst, 3'h3);
        n = wp_cnt;
        i_mcubfe_host_model.wr(8'h96);
        chk(wp_cnt - n, 1);
        chk(wdat, 8'h96);
        chk(addr, 16'h3ca5);
        $display("mux write done");
    endtask
    task automatic t_read();
        bsel = 1'b1;
        rdat = 8'h5a;
        i_mcubfe_host_model.addr_ph(16'h1234);
        i_mcubfe_host_model.rd(rv);
        chk(rv, 8'h5a);
        n = oe_cnt;
        bsel = 1'b0;
        i_mcubfe_host_model.rd(rv);
        chk(oe_cnt - n, 0);
        bsel = 1'b1;
        cs_n = 1'b1;
        step(4);
        chk(men, 1'b0);
        n = wp_cnt;
        m = oe_cnt;
        i_mcubfe_host_model.rd(rv);
        i_mcubfe_host_model.wr(8'h01);
        chk(oe_cnt - m, 0);
        chk(wp_cnt - n, 0);
        cs_n = 1'b0;
        step(4);
        chk(men, 1'b1);
        $display("read done");
    endtask
    task automatic t_styles();
        fuse = 1'b1;
        for (int s = 0; s < 4; s++) begin
            rsty = s[1:0];
            for (int v = 0; v < 2; v++) begin
                i_mcubfe_host_model.rd_n_o = v[0];
                step(5);
                chk(ctrl.read_n, (s == 1) ? !v[0] : v[0]);
                fetch = v[0];
                step(5);
                chk(ctrl.fetch_n, v[0]);
                chk(bst, {!v[0], 2'b11});
            end
        end
        rsty = MCUBFE_RSTYLE_RD_N;
        fuse = 1'b0;
        // Direction style: write pin high reads, low writes
        wdir = 1'b1;
        i_mcubfe_host_model.rd_n_o = 1'b0;
        step(5);
        chk({ctrl.write_n, ctrl.read_n}, 2'b10);
        i_mcubfe_host_model.wr_n_o = 1'b0;
        step(5);
        chk({ctrl.write_n, ctrl.read_n}, 2'b01);
        i_mcubfe_host_model.wr_n_o = 1'b1;
        i_mcubfe_host_model.rd_n_o = 1'b1;
        step(5);
        wdir = 1'b0;
        step(5);
        $display("styles done");
    endtask
    task automatic t_nonmux();
        mux = 1'b0;
        pa = 8'hc3;
        i_mcubfe_host_model.addr_ph(16'h0077);
        i_mcubfe_host_model.wr(8'h11);
        chk(wdat, 8'hc3);
        chk(ppin, {pc, pb, pa});
        mux = 1'b1;
        $display("nonmux done");
    endtask
    task automatic t_ports();
        ca = {{8{MCUBFE_PF_MCU_IO}}, 8'hff, 8'hff};
        cb = ca;
        cc = ca;
        pdir = 24'hff_ffff;
        pout = 24'hff_ffff;
        step(6);
        chk(poa.oe, 8'h0f);
        chk(poa.fast_slew[3:0], 4'hf);
        chk(pob.oe, 8'h0f);
        chk(poc.oe, 8'h00);
        pout = 24'h00_0000;
        step(6);
        chk({poc.oe, pob.oe, poa.oe}, 24'hff_ffff);
        chk(poa.dout, 8'h00);
        cc.func[1:0] = {2{MCUBFE_PF_JTAG}};
        pc = 8'h02;
        step(6);
        chk(jt, 2'h2);
        chk(poc.oe, 8'hfc);
        ca = {{8{MCUBFE_PF_LATCH_ADDR}}, 8'h00, 8'h00};
        cb = {{8{MCUBFE_PF_MCELL}}, 8'h00, 8'h00};
        mbc = 8'ha5;
        step(3);
        chk({pob.dout, poa.dout}, 16'ha577);
        chk(poa.oe & pob.oe, 8'hff);
        $display("ports done");
    endtask
    initial begin
        {mux, cs_n, bsel, fetch, reset_n} = 5'h16;
        {rsty, rdat, pa, pb, pc, pout, pdir} = '0;
        {wdir, fuse, mab, mbc} = '0;
        {ca, cb, cc} = '0;
        step(2);
        chk(addr, 16'h0000);
        chk(ctrl, 5'h1f);
        chk({lo_oe, poa.oe, pob.oe, poc.oe}, 32'h0000_0000);
        step(1);
        reset_n = 1'b1;
        t_mux_write();
        t_read();
        t_styles();
        t_nonmux();
        t_ports();
        reset_n = 1'b0;
        step(1);
        chk({addr, poa.oe}, 24'h00_0000);
        reset_n = 1'b1;
        complete_run();
    end
    // Roughly ten times the expected length of the whole run
    initial begin
        #20000;
        miscompares++;
        complete_run();
    end
endmodule
